// file: include/dds_pkg.sv
// Purpose: shared constants and types for the diagnostic read and sleep entry decoder
// Assumes: 100 MHz core clock, 8-bit command codes on the low data lines
// Notes:   every offset, code, reset value and cycle count lives here
package dds_pkg;

  // ----------------------------------------------------------------
  // Command codes and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_DIAG     = 8'h0F;
  localparam logic [7:0] CMD_SLEEP_ENTRY   = 8'h10;
  localparam logic [7:0] CMD_SLEEP_EXIT    = 8'h11;
  localparam int         DIAG_FLAG_LSB     = 4;     // Flags sit in bits 7..4
  localparam logic [7:0] DIAG_RESET        = 8'h00;
  localparam logic [7:0] DUMMY_WORD        = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int SETTLE_MS     = 120;               // Booster-off transition time
  localparam int SETTLE_CYC    = (CLK_HZ / 1000) * SETTLE_MS;
  localparam int SETTLE_W      = 24;
  localparam int VS_FALLS_FRAME = 2;                // Falling edges that make one frame

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_AWAKE  = 4'b0001,
    ST_BLANK  = 4'b0010,
    ST_SETTLE = 4'b0100,
    ST_ASLEEP = 4'b1000
  } dds_pwr_t;

  // Host pins after synchronising
  typedef struct packed {
    logic       serial_mode;
    logic       vertical_sync;
    logic       command_or_param_select;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic [7:0] data;
  } dds_pins_t;

  typedef struct packed {
    dds_pins_t meta;
    dds_pins_t stable;
  } dds_sync_t;

  typedef struct packed {
    dds_pwr_t            pwr;
    logic [1:0]          vs_falls;
    logic [SETTLE_W-1:0] settle_cnt;
    logic                rd_armed;
    logic                rd_dummy;
    logic [7:0]          diag;
    logic [7:0]          dout;
    logic                doe;
    logic                wr_q;
    logic                rd_q;
    logic                vs_q;
    logic                pump_en;
    logic                osc_en;
    logic                scan_en;
    logic                blank;
    logic                booster_off;
  } dds_state_t;

  localparam dds_pins_t PINS_RST = '{serial_mode: 1'b0, vertical_sync: 1'b1,
    command_or_param_select: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1, data: 8'h00};

  // Power-up and reset land in the sleep state with everything stopped
  localparam dds_state_t STATE_RST = '{pwr: ST_ASLEEP, vs_falls: 2'h0,
    settle_cnt: 24'h000000, rd_armed: 1'b0, rd_dummy: 1'b0, diag: DIAG_RESET,
    dout: 8'h00, doe: 1'b0, wr_q: 1'b1, rd_q: 1'b1, vs_q: 1'b1, pump_en: 1'b0,
    osc_en: 1'b0, scan_en: 1'b0, blank: 1'b0, booster_off: 1'b1};

endpackage : dds_pkg

// file: logic/dds_sync.sv
// Purpose: two-stage synchroniser for the host command pins and frame sync
// Assumes: pins are asynchronous to i_clock
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module dds_sync
  import dds_pkg::*;
(
  // Clock and reset
  input  wire logic      i_clock,
  input  wire logic      i_rst_n,
  // Pins in, stable copy out
  input  wire dds_pins_t i_pins,
  output dds_pins_t      o_pins
);

  dds_sync_t st_ff;
  dds_sync_t nxt_st;

  // Shift pins through both stages
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.meta   = i_pins;
    nxt_st.stable = st_ff.meta;
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_ff <= '{meta: PINS_RST, stable: PINS_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_pins = st_ff.stable;

endmodule : dds_sync

// file: logic/dds_diag_sleep.sv
// Purpose: decodes the diagnostic-result read and sleep entry commands
// Assumes: host pins are asynchronous; diagnostic flags come from core logic
// Notes:   the sleep exit code is decoded only to leave sleep
//
// Notes on behaviour
// [RQ1] Code 0FH arms the diagnostic byte read
// [RQ2] Byte holds four flags high, low nibble zero
// [RQ3] Diagnostic byte clears on any reset
// [RQ4] Both commands accepted in every power state
// [RQ5] Upper data lines ignored by the decoder
// [RQ6] Code 10H starts entry to sleep
// [RQ7] Asleep: pump, oscillator and scanning stopped
// [RQ8] Command port keeps working while asleep
// [RQ9] Blank panel for two vertical sync falls first
// [RQ10] Sleep entry while asleep changes nothing
// [RQ11] Only code 11H ends sleep
// [RQ12] Host waits 5 ms after sleep entry
// [RQ13] Host waits 120 ms after exit before re-entry
// [RQ14] Booster-off reached about 120 ms after entry
// [RQ15] Booster-off result shown for status bit 31
// [RQ16] Parallel mode returns dummy word before byte
// [RQ17] Any reset leaves the device asleep
`timescale 1ns/1ps
module dds_diag_sleep
  import dds_pkg::*;
#(
  parameter int unsigned P_SETTLE_CYCLES = SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_sw_reset,
  // Host command port pins
  input  wire logic        i_write_strobe_n,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_command_or_param_select,
  input  wire logic [17:0] i_data,
  input  wire logic        i_serial_mode,
  output logic      [7:0]  o_data,
  output logic             o_data_oe,
  // Frame timing and diagnostic sources
  input  wire logic        i_vertical_sync,
  input  wire logic [3:0]  i_diag_flags,
  // Power control and status
  output logic             o_pump_enable,
  output logic             o_osc_enable,
  output logic             o_scan_enable,
  output logic             o_blank_panel,
  output logic             o_booster_off
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_cmd(input logic [7:0] data, input logic [7:0] code);
    return data == code;
  endfunction : is_cmd

  function automatic logic fell(input logic now_v, input logic was_v);
    return was_v && !now_v;
  endfunction : fell

  // ----------------------------------------------------------------
  // Pin synchronising
  // ----------------------------------------------------------------
  dds_pins_t pins_raw;
  dds_pins_t pins;

  // Only the low byte goes in: upper lines are never looked at
  assign pins_raw = '{serial_mode: i_serial_mode, vertical_sync: i_vertical_sync,
    command_or_param_select: i_command_or_param_select,
    read_strobe_n: i_read_strobe_n, write_strobe_n: i_write_strobe_n,
    data: i_data[7:0]}; // RQ5

  dds_sync u_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_pins  (pins_raw),
    .o_pins  (pins)
  );

  // ----------------------------------------------------------------
  // Decode and power sequencing
  // ----------------------------------------------------------------
  dds_state_t st_ff;
  dds_state_t nxt_st;
  logic       cmd_wr;
  logic       rd_fall;
  logic       rd_rise;
  logic       vs_fall;
  logic       do_diag;
  logic       do_entry;
  logic       do_exit;

  // Strobe edges and command hits on the write strobe rising edge
  always_comb begin
    cmd_wr   = pins.write_strobe_n && !st_ff.wr_q && !pins.command_or_param_select;
    rd_fall  = fell(pins.read_strobe_n, st_ff.rd_q);
    rd_rise  = pins.read_strobe_n && !st_ff.rd_q;
    vs_fall  = fell(pins.vertical_sync, st_ff.vs_q);
    do_diag  = cmd_wr && is_cmd(pins.data, CMD_READ_DIAG);
    do_entry = cmd_wr && is_cmd(pins.data, CMD_SLEEP_ENTRY);
    do_exit  = cmd_wr && is_cmd(pins.data, CMD_SLEEP_EXIT);
  end

  // Next-state logic
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.wr_q  = pins.write_strobe_n;
    nxt_st.rd_q  = pins.read_strobe_n;
    nxt_st.vs_q  = pins.vertical_sync;
    // Flags live in the top nibble, low nibble forced to zero
    nxt_st.diag  = {i_diag_flags, 4'h0}; // RQ2

    // Any other command closes a pending diagnostic read
    if (cmd_wr) begin
      nxt_st.rd_armed = 1'b0;
    end
    // Decoding does not depend on power state
    if (do_diag) begin // RQ4 RQ8
      nxt_st.rd_armed = 1'b1; // RQ1
      nxt_st.rd_dummy = !pins.serial_mode; // RQ16
    end

    // Read cycles: dummy word first in parallel mode, then the byte
    if (rd_fall && st_ff.rd_armed) begin
      nxt_st.doe = 1'b1;
      if (st_ff.rd_dummy) begin
        nxt_st.dout     = DUMMY_WORD; // RQ16
        nxt_st.rd_dummy = 1'b0;
      end else begin
        nxt_st.dout     = st_ff.diag; // RQ1
        nxt_st.rd_armed = 1'b0;
      end
    end else if (rd_rise) begin
      nxt_st.doe = 1'b0;
    end

    unique case (st_ff.pwr)
      ST_AWAKE: begin
        if (do_entry) begin // RQ6
          nxt_st.pwr      = ST_BLANK;
          nxt_st.blank    = 1'b1; // RQ9
          nxt_st.vs_falls = 2'h0;
        end
      end
      ST_BLANK: begin
        if (vs_fall) begin
          nxt_st.vs_falls = st_ff.vs_falls + 2'h1;
        end
        if (vs_fall && st_ff.vs_falls == 2'(VS_FALLS_FRAME - 1)) begin // RQ9
          nxt_st.pwr        = ST_SETTLE;
          nxt_st.blank      = 1'b0;
          nxt_st.pump_en    = 1'b0; // RQ7
          nxt_st.osc_en     = 1'b0;
          nxt_st.scan_en    = 1'b0;
          nxt_st.settle_cnt = '0;
        end
      end
      ST_SETTLE: begin
        nxt_st.settle_cnt = st_ff.settle_cnt + 24'h000001;
        if (st_ff.settle_cnt == SETTLE_W'(P_SETTLE_CYCLES - 1)) begin // RQ14
          nxt_st.pwr         = ST_ASLEEP;
          nxt_st.booster_off = 1'b1; // RQ15
        end
      end
      ST_ASLEEP: begin
        // A repeated entry falls through here untouched
        nxt_st.pwr = ST_ASLEEP; // RQ10
      end
    endcase

    // Exit is the only way out of any sleep phase
    if (do_exit && st_ff.pwr != ST_AWAKE) begin // RQ11
      nxt_st.pwr         = ST_AWAKE;
      nxt_st.blank       = 1'b0;
      nxt_st.pump_en     = 1'b1;
      nxt_st.osc_en      = 1'b1;
      nxt_st.scan_en     = 1'b1;
      nxt_st.booster_off = 1'b0;
    end
  end

  // State register; software reset acts like the hardware one
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_sw_reset) begin
      st_ff <= STATE_RST; // RQ3 RQ17
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign o_data        = st_ff.dout;
  assign o_data_oe     = st_ff.doe;
  assign o_pump_enable = st_ff.pump_en;
  assign o_osc_enable  = st_ff.osc_en;
  assign o_scan_enable = st_ff.scan_en;
  assign o_blank_panel = st_ff.blank;
  assign o_booster_off = st_ff.booster_off;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_entry_awake;
    do_entry && st_ff.pwr == ST_AWAKE;
  endsequence

  sequence s_frame_done;
    st_ff.pwr == ST_BLANK && vs_fall && st_ff.vs_falls == 2'h1 && !do_exit;
  endsequence

  a_reset_clears: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> st_ff.diag == 8'h00 && st_ff.pwr == ST_ASLEEP) // RQ3 RQ17
    else $error("reset did not clear byte or enter sleep");

  a_diag_low_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_data_oe |-> o_data[3:0] == 4'h0) // RQ2
    else $error("low nibble of read data not zero");

  a_diag_arm: assert property (@(posedge i_clock) disable iff (!i_rst_n || i_sw_reset)
    do_diag |=> st_ff.rd_armed && st_ff.rd_dummy == !$past(pins.serial_mode)) // RQ1 RQ16
    else $error("diagnostic read not armed");

  a_diag_asleep: assert property (@(posedge i_clock) disable iff (!i_rst_n || i_sw_reset)
    do_diag && st_ff.pwr == ST_ASLEEP |=> st_ff.rd_armed) // RQ4 RQ8
    else $error("diagnostic read refused in sleep");

  a_dummy_first: assert property (@(posedge i_clock) disable iff (!i_rst_n || i_sw_reset)
    rd_fall && st_ff.rd_armed && st_ff.rd_dummy |=> o_data_oe && o_data == 8'h00
    && st_ff.rd_armed) // RQ16
    else $error("dummy word missing");

  a_entry_blank: assert property (@(posedge i_clock) disable iff (!i_rst_n || i_sw_reset)
    s_entry_awake |=> st_ff.pwr == ST_BLANK && o_blank_panel && o_scan_enable) // RQ6 RQ9
    else $error("sleep entry did not start blanking");

  a_frame_stop: assert property (@(posedge i_clock) disable iff (!i_rst_n || i_sw_reset)
    s_frame_done |=> st_ff.pwr == ST_SETTLE && !o_pump_enable && !o_osc_enable
    && !o_scan_enable && !o_blank_panel) // RQ7 RQ9
    else $error("blank frame did not stop the panel");

  a_asleep_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    st_ff.pwr == ST_ASLEEP |-> !o_pump_enable && !o_osc_enable && !o_scan_enable
    && o_booster_off) // RQ7 RQ15
    else $error("sleep with supplies running");

  a_sleep_holds: assert property (@(posedge i_clock) disable iff (!i_rst_n || i_sw_reset)
    st_ff.pwr == ST_ASLEEP && !do_exit |=> st_ff.pwr == ST_ASLEEP) // RQ10 RQ11
    else $error("sleep left without exit command");

  a_settle_end: assert property (@(posedge i_clock) disable iff (!i_rst_n || i_sw_reset)
    st_ff.pwr == ST_SETTLE && !do_exit
    && st_ff.settle_cnt == SETTLE_W'(P_SETTLE_CYCLES - 1)
    |=> st_ff.pwr == ST_ASLEEP && o_booster_off) // RQ14 RQ15
    else $error("booster-off not reached on time");

endmodule : dds_diag_sleep

// file: tb/dds_host.sv
// Purpose: host microcontroller model for the command port pins
// Assumes: pins change only on the falling clock edge
// Notes:   upper data lines idle high, then carry random levels from the first command write
`timescale 1ns/1ps
module dds_host
  import dds_pkg::*;
#(
  parameter int P_GAP = 30
) (
  // Clock
  input  wire logic   i_clock,
  // Command port pins
  output logic        o_write_strobe_n,
  output logic        o_read_strobe_n,
  output logic        o_command_or_param_select,
  output logic [17:0] o_data
);
  // Idle pin levels
  initial begin
    o_write_strobe_n          = 1'b1;
    o_read_strobe_n           = 1'b1;
    o_command_or_param_select = 1'b1;
    o_data                    = 18'h3FFFF;
  end

  // Command write, four cycles low and four high
  task automatic write_cmd(input logic [7:0] code);
    @(negedge i_clock);
    o_command_or_param_select = 1'b0;
    o_data = {10'($urandom), code};
    o_write_strobe_n = 1'b0;
    repeat (4) @(negedge i_clock);
    o_write_strobe_n = 1'b1;
    repeat (4) @(negedge i_clock);
    o_command_or_param_select = 1'b1;
    o_data = ~o_data;  // Released lines never keep the old value
    // Settling gap after sleep entry and sleep exit
    if (code == CMD_SLEEP_ENTRY || code == CMD_SLEEP_EXIT) begin
      repeat (P_GAP) @(negedge i_clock);
    end
  endtask : write_cmd

  // Parameter read, six cycles low and six high; dummy word noted by caller, checked by the read monitor
  task automatic read_word();
    @(negedge i_clock);
    o_read_strobe_n = 1'b0;
    repeat (6) @(negedge i_clock);
    o_read_strobe_n = 1'b1;
    repeat (6) @(negedge i_clock);
  endtask : read_word
endmodule : dds_host

// file: tb/tb_dds_diag_sleep.sv
// Purpose: self-checking bench for the diagnostic read and sleep entry decoder
// Assumes: settle count shortened to 20 cycles
// Notes:   read results checked by a queue-driven monitor
`timescale 1ns/1ps
module tb_dds_diag_sleep
  import dds_pkg::*;
;
  localparam int P_SET = 20;
  logic        i_clock, i_rst_n, i_sw_reset, i_serial_mode, i_vertical_sync;
  logic        wr_n, rd_n, dcx, o_data_oe, pump, osc, scan, blank, boost;
  logic [17:0] pin_data;
  logic [7:0]  o_data;
  logic [3:0]  i_diag_flags;
  logic [7:0]  exp_q[$];
  logic        oe_q = 1'b0;
  int          bad_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  dds_diag_sleep #(.P_SETTLE_CYCLES(P_SET)) dds_diag_sleep_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sw_reset(i_sw_reset),
    .i_write_strobe_n(wr_n), .i_read_strobe_n(rd_n), .i_command_or_param_select(dcx),
    .i_data(pin_data), .i_serial_mode(i_serial_mode), .o_data(o_data),
    .o_data_oe(o_data_oe), .i_vertical_sync(i_vertical_sync),
    .i_diag_flags(i_diag_flags), .o_pump_enable(pump), .o_osc_enable(osc),
    .o_scan_enable(scan), .o_blank_panel(blank), .o_booster_off(boost));

  dds_host dds_host_i (
    .i_clock(i_clock), .o_write_strobe_n(wr_n), .o_read_strobe_n(rd_n),
    .o_command_or_param_select(dcx), .o_data(pin_data));

  // Clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Comparison and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  // Power outputs packed as {pump, osc, scan, blank, booster_off}
  function automatic logic [7:0] pw();
    return {3'h0, pump, osc, scan, blank, boost};
  endfunction : pw

  // Diagnostic read: notes dummy (parallel mode only) and byte, then one extra read that must stay undriven
  task automatic diag_read(input logic ser, input logic [3:0] f);
    i_serial_mode = ser;
    i_diag_flags  = f;
    dds_host_i.write_cmd(CMD_READ_DIAG);
    if (!ser) begin
      exp_q.push_back(8'h00);
      dds_host_i.read_word();
    end
    exp_q.push_back({f, 4'h0});
    dds_host_i.read_word();
    dds_host_i.read_word();
  endtask : diag_read

  task automatic vs_fall();
    @(negedge i_clock);
    i_vertical_sync = 1'b0;
    repeat (4) @(negedge i_clock);
    i_vertical_sync = 1'b1;
    repeat (8) @(negedge i_clock);
  endtask : vs_fall

  // Read monitor: each rise of the output enable takes the oldest note.
  // Sampled on the falling edge, so the registered outputs have settled.
  always @(negedge i_clock) begin
    oe_q <= o_data_oe;
    if (o_data_oe === 1'b1 && oe_q !== 1'b1) begin
      if (exp_q.size() == 0) check(o_data, 8'hXX);
      else check(o_data, exp_q.pop_front());
    end
  end

  // Hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h4BB5820A));
    i_rst_n = 1'b0;
    i_sw_reset = 1'b0;
    i_serial_mode = 1'b0;
    i_vertical_sync = 1'b1;
    i_diag_flags = 4'h0;
    repeat (3) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    check(pw(), 8'h01);
    diag_read(1'b0, 4'h0);
    dds_host_i.write_cmd(CMD_SLEEP_ENTRY);
    check(pw(), 8'h01);
    diag_read(1'b0, 4'($urandom));
    dds_host_i.write_cmd(CMD_READ_DIAG);
    dds_host_i.write_cmd(8'h20 | 8'($urandom % 16));
    dds_host_i.read_word();
    check(pw(), 8'h01);
    dds_host_i.write_cmd(CMD_SLEEP_EXIT);
    check(pw(), 8'h1C);
    diag_read(1'b1, 4'($urandom));
    i_serial_mode = 1'b0;
    dds_host_i.write_cmd(CMD_SLEEP_ENTRY);
    check(pw(), 8'h1E);
    vs_fall();
    check(pw(), 8'h1E);
    vs_fall();
    check(pw(), 8'h00);
    repeat (P_SET + 8) @(negedge i_clock);
    check(pw(), 8'h01);
    diag_read(1'b0, 4'($urandom));
    dds_host_i.write_cmd(CMD_SLEEP_EXIT);
    check(pw(), 8'h1C);
    @(negedge i_clock);
    i_sw_reset = 1'b1;
    @(negedge i_clock);
    i_sw_reset = 1'b0;
    repeat (4) @(negedge i_clock);
    check(pw(), 8'h01);
    check(8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule : tb_dds_diag_sleep
